/* File: isw_bank.sv */
// inspection status word bank with backplane, remote and serial views
`timescale 1ns/10ps
`include "isw_map.svh"
module isw_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // vision engine events
  input wire logic [1:0] insp_done_i,
  input wire isw_pkg::isw_result_t result1_i,
  input wire isw_pkg::isw_result_t result2_i,
  input wire logic [1:0] trig_miss_i,
  // configuration and mode state
  input wire logic cfg_bad_write_i,
  input wire logic cfg_validate_err_i,
  input wire logic cfg_accept_i,
  input wire logic setup_mode_i,
  input wire logic download_i,
  input wire isw_pkg::isw_owner_t host_owner_i,
  // backplane read port
  input wire logic bp_rd_i,
  input wire logic [8:0] bp_addr_i,
  output logic bp_ack_o,
  output logic bp_err_o,
  output logic [15:0] bp_data_o,
  // remote link read port
  input wire logic rio_rd_i,
  input wire logic [1:0] rio_addr_i,
  input wire logic [15:0] rio_out_word3_i,
  output logic rio_ack_o,
  output logic [15:0] rio_data_o,
  // serial port read path
  input wire logic ser_rd_i,
  input wire logic ser_ts_i,
  input wire logic [1:0] ser_addr_i,
  output logic ser_ack_o,
  output logic [15:0] ser_data_o
);
  import isw_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // two stages so the release is clean against clk_i
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // per toolset result words
  // ----------------------------------------------------------------
  isw_ts_words_t ts1_words;
  isw_ts_words_t ts2_words;

  isw_toolset u_ts1 (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .done_i(insp_done_i[0]),
    .result_i(result1_i),
    .words_o(ts1_words)
  );

  isw_toolset u_ts2 (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .done_i(insp_done_i[1]),
    .result_i(result2_i),
    .words_o(ts2_words)
  );

  // ----------------------------------------------------------------
  // shared status flags
  // ----------------------------------------------------------------
  logic cfg_err_q;
  logic busy_q;
  logic setup_prev_q;
  logic setup_enter;
  logic [1:0] miss_q;
  logic [1:0] valid_q;
  logic any_done;

  assign setup_enter = setup_mode_i & ~setup_prev_q;
  assign any_done = |insp_done_i;

  // config error: a new fault wins over an accepted configuration
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_err_q <= 1'b0;
    end else if (cfg_bad_write_i) begin
      cfg_err_q <= 1'b1; // RULE1
    end else if (cfg_validate_err_i) begin
      cfg_err_q <= 1'b1; // RULE2
    end else if (cfg_accept_i) begin
      cfg_err_q <= 1'b0;
    end
  end

  // busy follows setup mode and download activity
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      setup_prev_q <= 1'b0;
    end else begin
      busy_q <= setup_mode_i | download_i; // RULE5 RULE6
      setup_prev_q <= setup_mode_i;
    end
  end

  // missed triggers stick until the next finished inspection
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      miss_q <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (trig_miss_i[k]) begin
          miss_q[k] <= 1'b1; // RULE9
        end else if (any_done) begin
          miss_q[k] <= 1'b0; // RULE11
        end
      end
    end
  end

  // results valid per toolset, dropped on entry into setup
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (insp_done_i[k]) begin
          valid_q[k] <= 1'b1; // RULE11
        end else if (setup_enter) begin
          valid_q[k] <= 1'b0; // RULE7
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  // build a general word; owner bit depends on who is reading
  function automatic logic [15:0] gen_word(input logic [15:0] hi, input logic owner);
    logic [15:0] w;
    w = hi;
    w[`ISW_B_CFGERR] = cfg_err_q;
    w[`ISW_B_OWNER] = owner; // RULE3
    w[`ISW_B_BUSY] = busy_q;
    w[`ISW_B_MISS1] = miss_q[0];
    w[`ISW_B_MISS2] = miss_q[1];
    w[`ISW_B_VALID1] = valid_q[0];
    w[`ISW_B_VALID2] = valid_q[1];
    return w;
  endfunction

  // pick one of the three words of a toolset by link index
  function automatic logic [15:0] link_word(input isw_ts_words_t ts, input logic [1:0] idx,
                                            input logic owner);
    logic [15:0] w;
    w = 16'h0000;
    if (idx == `ISW_LNK_GEN) begin
      w = gen_word(ts.gen_hi, owner);
    end else if (idx == `ISW_LNK_WINA) begin
      w = ts.win_a;
    end else if (idx == `ISW_LNK_WINB) begin
      w = ts.win_b;
    end
    return w;
  endfunction

  logic bp_owner;
  logic rio_owner;
  logic rio_pick_ts2;

  assign bp_owner = (host_owner_i == ISW_OWN_BP); // RULE3
  assign rio_owner = (host_owner_i == ISW_OWN_RIO); // RULE3
  // toolset 2 only when its select bit alone is set
  assign rio_pick_ts2 = rio_out_word3_i[`ISW_SEL_TS2] &
                        ~rio_out_word3_i[`ISW_SEL_TS1]; // RULE10

  // ----------------------------------------------------------------
  // backplane read port
  // ----------------------------------------------------------------
  logic [15:0] bp_data_d;
  logic bp_err_d;

  // address decode; unmapped words read zero with error
  always_comb begin
    bp_data_d = `ISW_RST_WORD;
    bp_err_d = 1'b0;
    if (bp_addr_i == `ISW_TS1_GEN) begin
      bp_data_d = gen_word(ts1_words.gen_hi, bp_owner);
    end else if (bp_addr_i == `ISW_TS1_WINA) begin
      bp_data_d = ts1_words.win_a;
    end else if (bp_addr_i == `ISW_TS1_WINB) begin
      bp_data_d = ts1_words.win_b;
    end else if (bp_addr_i == `ISW_TS2_GEN) begin
      bp_data_d = gen_word(ts2_words.gen_hi, bp_owner);
    end else if (bp_addr_i == `ISW_TS2_WINA) begin
      bp_data_d = ts2_words.win_a;
    end else if (bp_addr_i == `ISW_TS2_WINB) begin
      bp_data_d = ts2_words.win_b;
    end else begin
      bp_err_d = 1'b1;
    end
  end

  logic [15:0] bp_data_q;
  logic bp_ack_q;
  logic bp_err_q;

  // answer one cycle after the strobe; data held until next read
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bp_data_q <= `ISW_RST_WORD;
      bp_ack_q <= 1'b0;
      bp_err_q <= 1'b0;
    end else begin
      bp_ack_q <= bp_rd_i;
      if (bp_rd_i) begin
        bp_data_q <= bp_data_d;
        bp_err_q <= bp_err_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // remote link read port
  // ----------------------------------------------------------------
  logic [15:0] rio_data_q;
  logic rio_ack_q;

  // the selected toolset feeds all link words
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rio_data_q <= `ISW_RST_WORD;
      rio_ack_q <= 1'b0;
    end else begin
      rio_ack_q <= rio_rd_i;
      if (rio_rd_i) begin
        rio_data_q <= rio_pick_ts2 ? link_word(ts2_words, rio_addr_i, rio_owner) :
                      link_word(ts1_words, rio_addr_i, rio_owner); // RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // serial read path
  // ----------------------------------------------------------------
  logic [15:0] ser_data_q;
  logic ser_ack_q;

  // serial ports have no ownership notion, so bit 2 stays low
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_data_q <= `ISW_RST_WORD;
      ser_ack_q <= 1'b0;
    end else begin
      ser_ack_q <= ser_rd_i;
      if (ser_rd_i) begin
        ser_data_q <= ser_ts_i ? link_word(ts2_words, ser_addr_i, 1'b0) :
                      link_word(ts1_words, ser_addr_i, 1'b0); // RULE4
      end
    end
  end

  // outputs
  assign bp_ack_o = bp_ack_q;
  assign bp_err_o = bp_err_q;
  assign bp_data_o = bp_data_q;
  assign rio_ack_o = rio_ack_q;
  assign rio_data_o = rio_data_q;
  assign ser_ack_o = ser_ack_q;
  assign ser_data_o = ser_data_q;
endmodule

/* File: isw_map.svh */
// constants for the inspection status word bank
// How it works
// RULE1: bad config or template write sets config error
// RULE2: validation errors also set config error bit
// RULE3: bit 2 reads one only for owning host
// RULE4: ownership bit reads zero over serial ports
// RULE5: busy bit high throughout setup mode
// RULE6: busy also high during downloads, else low
// RULE7: setup entry clears both results valid flags
// RULE8: master fault high when any tool fails
// RULE9: trigger, reference, probe and window flag layout
// RULE10: host picks remote toolset via output word bits
// RULE11: status bits refresh with every inspection
`ifndef ISW_MAP_SVH
`define ISW_MAP_SVH
// ----------------------------------------------------------------
// word offsets on the backplane
// ----------------------------------------------------------------
`define ISW_TS1_GEN 9'h010
`define ISW_TS1_WINA 9'h011
`define ISW_TS1_WINB 9'h012
`define ISW_TS2_GEN 9'h118
`define ISW_TS2_WINA 9'h119
`define ISW_TS2_WINB 9'h11a
// ----------------------------------------------------------------
// word index on the remote and serial links
// ----------------------------------------------------------------
`define ISW_LNK_GEN 2'h0
`define ISW_LNK_WINA 2'h1
`define ISW_LNK_WINB 2'h2
// ----------------------------------------------------------------
// general word bit positions
// ----------------------------------------------------------------
`define ISW_B_CFGERR 1
`define ISW_B_OWNER 2
`define ISW_B_BUSY 3
`define ISW_B_MISS1 4
`define ISW_B_MISS2 5
`define ISW_B_VALID1 6
`define ISW_B_VALID2 7
`define ISW_B_REF 8
`define ISW_B_PROBE 14
`define ISW_B_MFAULT 15
// toolset select bits in discrete output word 3
`define ISW_SEL_TS1 4
`define ISW_SEL_TS2 5
// number of windows per toolset in this bank
`define ISW_NWIN 10
`define ISW_RST_WORD 16'h0000
`endif

/* File: isw_pkg.sv */
// types for the inspection status word bank
`include "isw_map.svh"
package isw_pkg;
  // one inspection's outcome as delivered by the vision engine
  typedef struct packed {
    logic [5:0] ref_fail; // lines 1-3 then windows 1-3
    logic probe_fail;
    logic [`ISW_NWIN-1:0] win_warn;
    logic [`ISW_NWIN-1:0] win_fault;
  } isw_result_t;
  // which link currently holds host ownership
  typedef enum logic [1:0] {
    ISW_OWN_NONE = 2'h0,
    ISW_OWN_BP = 2'h1,
    ISW_OWN_RIO = 2'h3
  } isw_owner_t;
  // stored words of one toolset
  typedef struct packed {
    logic [15:0] gen_hi; // bits 8-15 of general word
    logic [15:0] win_a;
    logic [15:0] win_b;
  } isw_ts_words_t;
endpackage

/* File: isw_toolset.sv */
// result words of one toolset, refreshed at each inspection
`timescale 1ns/10ps
`include "isw_map.svh"
module isw_toolset (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // inspection results
  input wire logic done_i,
  input wire isw_pkg::isw_result_t result_i,
  // stored words
  output isw_pkg::isw_ts_words_t words_o
);
  import isw_pkg::*;

  logic [15:0] gen_d;
  logic [31:0] win_d;
  isw_ts_words_t words_q;

  // interleave warning and fault flags, two bits per window
  always_comb begin
    win_d = 32'h00000000;
    for (int k = 0; k < `ISW_NWIN; k++) begin
      win_d[2*k] = result_i.win_warn[k]; // RULE9
      win_d[2*k+1] = result_i.win_fault[k]; // RULE9
    end
  end

  // reference, probe and master fault bits of the general word
  always_comb begin
    gen_d = 16'h0000;
    gen_d[`ISW_B_REF +: 6] = result_i.ref_fail; // RULE9
    gen_d[`ISW_B_PROBE] = result_i.probe_fail; // RULE9
    gen_d[`ISW_B_MFAULT] = |result_i.ref_fail | result_i.probe_fail |
                           |result_i.win_fault; // RULE8
  end

  // capture a new set of words with each finished inspection
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      words_q <= '0;
    end else if (done_i) begin
      words_q.gen_hi <= gen_d; // RULE11
      words_q.win_a <= win_d[15:0]; // RULE11
      words_q.win_b <= win_d[31:16]; // RULE11
    end
  end

  assign words_o = words_q;
endmodule

/* File: isw_bank_chk.sv */
// concurrent checks on the status word bank ports
`timescale 1ns/10ps
module isw_bank_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // events and modes
  input wire logic [1:0] insp_done_i,
  input wire logic cfg_bad_write_i,
  input wire logic cfg_validate_err_i,
  input wire logic setup_mode_i,
  input wire logic download_i,
  input wire isw_pkg::isw_owner_t host_owner_i,
  // read ports
  input wire logic bp_rd_i,
  input wire logic [8:0] bp_addr_i,
  input wire logic bp_ack_o,
  input wire logic bp_err_o,
  input wire logic [15:0] bp_data_o,
  input wire logic rio_rd_i,
  input wire logic rio_ack_o,
  input wire logic ser_rd_i,
  input wire logic [1:0] ser_addr_i,
  input wire logic ser_ack_o,
  input wire logic [15:0] ser_data_o
);
  import isw_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_gen_rd;
    bp_rd_i && bp_addr_i == 9'h010;
  endsequence
  // setup entered with no inspection landing meanwhile
  sequence s_enter_setup;
    $rose(setup_mode_i) && insp_done_i == 2'h0 ##1 (setup_mode_i && insp_done_i == 2'h0)[*2];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_BP_ACK: assert property (bp_ack_o == $past(bp_rd_i))
    else $error("bp ack not one cycle after strobe");
  AST_RIO_ACK: assert property (rio_ack_o == $past(rio_rd_i))
    else $error("remote ack not one cycle after strobe");
  AST_SER_ACK: assert property (ser_ack_o == $past(ser_rd_i))
    else $error("serial ack not one cycle after strobe");
  AST_BP_ERR: assert property (bp_rd_i && !(bp_addr_i inside {9'h010, 9'h011, 9'h012,
    9'h118, 9'h119, 9'h11a}) |=> bp_err_o && bp_data_o == 16'h0000)
    else $error("unmapped read not refused");
  AST_GEN_OK: assert property (s_gen_rd |=> !bp_err_o && !bp_data_o[0])
    else $error("general word read bad");
  AST_CFG_ERR: assert property ((cfg_bad_write_i || cfg_validate_err_i) ##1 s_gen_rd
    |=> bp_data_o[1])
    else $error("config error not set");
  AST_BUSY: assert property (s_gen_rd
    |=> bp_data_o[3] == ($past(setup_mode_i, 2) || $past(download_i, 2)))
    else $error("busy bit wrong");
  AST_OWNER: assert property ((s_gen_rd and $stable(host_owner_i))
    |=> bp_data_o[2] == ($past(host_owner_i) == ISW_OWN_BP))
    else $error("ownership bit wrong");
  AST_SER_OWNER: assert property (ser_rd_i && ser_addr_i == 2'h0 |=> !ser_data_o[2])
    else $error("serial ownership bit set");
  AST_MFAULT: assert property (s_gen_rd |=> !(|bp_data_o[14:8]) || bp_data_o[15])
    else $error("master fault missing");
  AST_VALID_CLR: assert property (s_enter_setup ##0 s_gen_rd |=> bp_data_o[7:6] == 2'h0)
    else $error("valid flags kept in setup");
endmodule
bind isw_bank isw_bank_chk chk (.clk_i, .nrst_i, .insp_done_i, .cfg_bad_write_i,
  .cfg_validate_err_i, .setup_mode_i, .download_i, .host_owner_i, .bp_rd_i, .bp_addr_i,
  .bp_ack_o, .bp_err_o, .bp_data_o, .rio_rd_i, .rio_ack_o, .ser_rd_i, .ser_addr_i,
  .ser_ack_o, .ser_data_o);

/* File: isw_host.sv */
// host controller model on the remote link
`timescale 1ns/10ps
module isw_host (
  // clock
  input wire logic clk_i,
  // answer from the bank
  input wire logic rio_ack_i,
  input wire logic [15:0] rio_data_i,
  // request to the bank
  output logic rio_rd_o,
  output logic [1:0] rio_addr_o,
  output logic [15:0] word3_o
);
  // idle request lines
  initial begin
    rio_rd_o = 1'b0;
    rio_addr_o = 2'h0;
    word3_o = 16'h0000;
  end
  // pick the toolset one cycle ahead, then read one word
  task automatic read(input logic [15:0] w3, input logic [1:0] a, output logic [15:0] d,
    output logic ok);
    int i;
    @(posedge clk_i);
    #1 word3_o = w3;
    @(posedge clk_i);
    #1 rio_rd_o = 1'b1;
    rio_addr_o = a;
    i = 0;
    do begin
      @(posedge clk_i);
      #1 i++;
    end while (rio_ack_i !== 1'b1 && i < 8);
    d = rio_data_i;
    ok = i < 8;
    @(posedge clk_i);
    #1 rio_rd_o = 1'b0;
    rio_addr_o = ~a;
  endtask
endmodule

/* File: isw_bank_bench.sv */
// self-checking bench for the status word bank
`timescale 1ns/10ps
module isw_bank_bench;
  import isw_pkg::*;
  logic clk_i, nrst_i, cfg_bad_write_i, cfg_validate_err_i, cfg_accept_i, setup_mode_i;
  logic download_i, bp_rd_i, bp_ack_o, bp_err_o, rio_rd_i, rio_ack_o, ser_rd_i, ser_ts_i;
  logic ser_ack_o, cfg, busy, hok;
  logic [1:0] insp_done_i, trig_miss_i, rio_addr_i, ser_addr_i, valid, miss;
  logic [8:0] bp_addr_i;
  logic [15:0] bp_data_o, rio_data_o, ser_data_o, rio_out_word3_i, hrd;
  logic [7:0] hi [2];
  logic [15:0] wa [2], wb [2];
  isw_result_t result1_i, result2_i;
  isw_owner_t host_owner_i;
  int n_fail, checks;
  logic [8:0] base [2] = '{9'h010, 9'h118};
  logic [15:0] w3 [4] = '{16'h0020, 16'h0010, 16'h0030, 16'h0000};
  // device and host
  isw_bank uut (.clk_i, .nrst_i, .insp_done_i, .result1_i, .result2_i, .trig_miss_i,
    .cfg_bad_write_i, .cfg_validate_err_i, .cfg_accept_i, .setup_mode_i, .download_i,
    .host_owner_i, .bp_rd_i, .bp_addr_i, .bp_ack_o, .bp_err_o, .bp_data_o, .rio_rd_i,
    .rio_addr_i, .rio_out_word3_i, .rio_ack_o, .rio_data_o, .ser_rd_i, .ser_ts_i,
    .ser_addr_i, .ser_ack_o, .ser_data_o);
  isw_host host (.clk_i, .rio_ack_i(rio_ack_o), .rio_data_i(rio_data_o), .rio_rd_o(rio_rd_i),
    .rio_addr_o(rio_addr_i), .word3_o(rio_out_word3_i));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] eg(input int ts, input logic own);
    return {hi[ts], valid, miss, busy, own, cfg, 1'b0};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one read on the backplane (p 0) or serial port (p 1, a[8] toolset)
  task automatic rc(input int p, input logic [8:0] a, input logic [15:0] x, input logic xe);
    int i;
    logic [15:0] d;
    logic e;
    @(posedge clk_i);
    #1 if (p == 0) begin
      bp_rd_i = 1'b1;
      bp_addr_i = a;
    end else begin
      ser_rd_i = 1'b1;
      ser_ts_i = a[8];
      ser_addr_i = a[1:0];
    end
    i = 0;
    do begin
      @(posedge clk_i);
      #1 i++;
    end while ((p == 0 ? bp_ack_o : ser_ack_o) !== 1'b1 && i < 8);
    d = p == 0 ? bp_data_o : ser_data_o;
    e = p == 0 ? bp_err_o : 1'b0;
    @(posedge clk_i);
    #1 bp_rd_i = 1'b0;
    ser_rd_i = 1'b0;
    bp_addr_i = ~a;
    if (i == 8) begin
      n_fail++;
      $display("unexpected at %0t: no ack", $time);
      close_out;
    end
    chk(d, x);
    chk({15'h0, e}, {15'h0, xe});
  endtask
  task automatic hrc(input logic [15:0] w, input logic [1:0] a, input logic [15:0] x);
    host.read(w, a, hrd, hok);
    if (!hok) begin
      n_fail++;
      $display("unexpected at %0t: no remote ack", $time);
      close_out;
    end
    chk(hrd, x);
  endtask
  task automatic rwords(input int ts);
    rc(0, base[ts], eg(ts, host_owner_i == ISW_OWN_BP), 1'b0);
    rc(0, base[ts] + 9'h001, wa[ts], 1'b0);
    rc(0, base[ts] + 9'h002, wb[ts], 1'b0);
  endtask
  // deliver one inspection and update the expected words
  task automatic insp(input int ts, input isw_result_t r);
    if (ts == 0) result1_i = r;
    else result2_i = r;
    insp_done_i[ts] = 1'b1;
    @(posedge clk_i);
    #1 insp_done_i = 2'h0;
    hi[ts] = {(|r.ref_fail) | r.probe_fail | (|r.win_fault), r.probe_fail, r.ref_fail};
    for (int k = 0; k < 8; k++) begin
      wa[ts][2*k] = r.win_warn[k];
      wa[ts][2*k+1] = r.win_fault[k];
    end
    wb[ts] = {12'h000, r.win_fault[9], r.win_warn[9], r.win_fault[8], r.win_warn[8]};
    valid[ts] = 1'b1;
    miss = 2'h0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {nrst_i, cfg_bad_write_i, cfg_validate_err_i, cfg_accept_i, setup_mode_i} = '0;
    {download_i, bp_rd_i, ser_rd_i, ser_ts_i, insp_done_i, trig_miss_i, ser_addr_i} = '0;
    {bp_addr_i, result1_i, result2_i, valid, miss, cfg, busy} = '0;
    host_owner_i = ISW_OWN_NONE;
    hi = '{8'h00, 8'h00};
    wa = '{16'h0000, 16'h0000};
    wb = '{16'h0000, 16'h0000};
    n_fail = 0;
    checks = 0;
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rwords(0);
    rwords(1);
    rc(0, 9'h013, 16'h0000, 1'b1);
    rc(0, 9'h117, 16'h0000, 1'b1);
    $display("test reset done");
    host_owner_i = ISW_OWN_BP;
    trig_miss_i = 2'h3;
    miss = 2'h3;
    rc(0, 9'h010, eg(0, 1'b1), 1'b0);
    trig_miss_i = 2'h0;
    insp(0, {6'h00, 1'b0, 10'h3ff, 10'h000});
    insp(1, {6'h2a, 1'b1, 10'h000, 10'h201});
    rwords(0);
    rwords(1);
    insp(0, {6'h00, 1'b0, 10'h000, 10'h200});
    rwords(0);
    for (int ts = 0; ts < 2; ts++) begin
      rc(1, {ts[0], 8'h00}, eg(ts, 1'b0), 1'b0);
      rc(1, {ts[0], 8'h02}, wb[ts], 1'b0);
    end
    $display("test inspection done");
    host_owner_i = ISW_OWN_RIO;
    for (int j = 0; j < 4; j++) begin
      hrc(w3[j], 2'h0, eg(j == 0, 1'b1));
      hrc(w3[j], 2'h1, wa[j == 0]);
    end
    hrc(16'h0000, 2'h3, 16'h0000);
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    $display("test remote done");
    cfg_bad_write_i = 1'b1;
    cfg = 1'b1;
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    cfg_bad_write_i = 1'b0;
    cfg_accept_i = 1'b1;
    cfg = 1'b0;
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    cfg_accept_i = 1'b0;
    cfg_validate_err_i = 1'b1;
    cfg = 1'b1;
    rc(0, 9'h118, eg(1, 1'b0), 1'b0);
    cfg_validate_err_i = 1'b0;
    $display("test config done");
    setup_mode_i = 1'b1;
    valid = 2'h0;
    busy = 1'b1;
    @(posedge clk_i);
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    rc(0, 9'h118, eg(1, 1'b0), 1'b0);
    setup_mode_i = 1'b0;
    busy = 1'b0;
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    download_i = 1'b1;
    busy = 1'b1;
    @(posedge clk_i);
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    download_i = 1'b0;
    busy = 1'b0;
    rc(0, 9'h010, eg(0, 1'b0), 1'b0);
    $display("test busy done");
    close_out;
  end
endmodule
